// ==== hvdp_cfg.svh ====
// register offsets, field positions and reset values of the drive protect block
`ifndef HVDP_CFG_SVH
`define HVDP_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define HVDP_ADDR_W        4
`define HVDP_OFS_DRIVE     4'h0
`define HVDP_OFS_PROT      4'h1

// ----------------------------------------------------------------------------
// field positions of the drive control register
// ----------------------------------------------------------------------------
`define HVDP_BIT_LEVEL     0
`define HVDP_BIT_SRC_SEL   1
`define HVDP_BIT_OE        2
`define HVDP_BIT_PROT_EN   3

// ----------------------------------------------------------------------------
// field positions of the protect source register
// ----------------------------------------------------------------------------
`define HVDP_BIT_OC_EN     0
`define HVDP_BIT_IRQ_EN    1
`define HVDP_BIT_SRC2_EN   2
`define HVDP_BIT_SRC3_EN   3

// ----------------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------------
`define HVDP_CTRL_W        4
`define HVDP_DRIVE_RST     4'h0
`define HVDP_PROT_RST      4'h0
`define HVDP_OE_DELAY      1

`endif

// ==== hvdp_mos.sv ====
// power switch gate seen from the drive pin
`timescale 1ns/1ps
`default_nettype none

module hvdp_mos (
  // clock
  input  wire logic ref_clk,
  // pin
  input  wire logic gate_o,
  input  wire logic gate_oe,
  // load fault and its sense
  input  wire logic short_fault,
  output logic      gate,
  output logic      overcurrent_flag
);
  // gate resistor pulls low while the pin floats
  assign gate = gate_oe ? gate_o : 1'b0;
  // current only flows, and so trips the sense, while the switch is on
  always_ff @(posedge ref_clk) begin
    overcurrent_flag <= gate & short_fault;
  end
endmodule
`default_nettype wire

// ==== hvdp_pin.sv ====
// pin stage: enable leads data by one system clock
`timescale 1ns/1ps
`default_nettype none
`include "hvdp_cfg.svh"

module hvdp_pin
  import hvdp_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // control
  input  wire logic oe,
  input  wire logic level,
  // pin
  output hvdp_pin_t pin
);

  logic oe_r;
  logic level_r;

  // data holds on any edge that moves the enable, in either direction, so
  // the two never switch together at the level shifter; the cost is one
  // extra cycle before a floating pin's data returns to zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      oe_r    <= oe;
      if (oe != oe_r) begin
        level_r <= level_r;
      end else begin
        level_r <= oe_r ? level : 1'b0;
      end
    end
  end

  assign pin.oe = oe_r;
  assign pin.o  = level_r;

endmodule
`default_nettype wire

// ==== hvdp_pkg.sv ====
// types shared by the drive protect block
package hvdp_pkg;

  typedef struct packed {
    logic prot_en;
    logic oe;
    logic src_sel;
    logic level;
  } hvdp_drive_t;

  typedef struct packed {
    logic src3_en;
    logic src2_en;
    logic irq_en;
    logic oc_en;
  } hvdp_prot_t;

  typedef struct packed {
    logic protect_input_3;
    logic protect_input_2;
    logic ext_irq;
    logic overcurrent_flag;
  } hvdp_src_t;

  typedef struct packed {
    logic o;
    logic oe;
  } hvdp_pin_t;

endpackage

// ==== hvdp_top.sv ====
// high voltage drive with hardware protection: registers and pin control
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hvdp_cfg.svh"

// How it works
// - source select 0 drives the pin from the level bit, 1 from the timer.
// - the level bit drives the pin low when 0 and high when 1.
// - output enable 0 floats the pin and 1 drives it.
// - with protection off no control bit is ever forced by hardware.
// - with protection on a trigger rise clears level and source select.
// - with protection on and no rise those two bits are left alone.
// - a register write moves the enable one cycle ahead of the data.
// - protect enable bit 0 admits overcurrent, bit 1 the external irq.
// - protect enable bits 3 and 2 admit extra inputs 3 and 2.
// - bits 7 to 4 of both registers read as zero.
module hvdp_top
  import hvdp_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     arst_n,
  // register port
  input  wire logic [`HVDP_ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // protection sources and timer
  input  wire logic                     overcurrent_flag,
  input  wire logic                     ext_irq,
  input  wire logic                     protect_input_2,
  input  wire logic                     protect_input_3,
  input  wire logic                     timer_drive_signal,
  // high voltage pin
  output logic                          hv_pin_o,
  output logic                          hv_pin_oe,
  // status
  output logic                          protect_trip
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  hvdp_drive_t drive_r;
  hvdp_prot_t  prot_r;
  hvdp_src_t   src;
  hvdp_pin_t   pin;
  logic        rise;
  logic        wr_drive;
  logic        level_sel;
  logic        trip_r;

  function automatic logic [7:0] pad4(input logic [3:0] v);
    pad4 = {4'h0, v};
  endfunction

  assign src.overcurrent_flag = overcurrent_flag;
  assign src.ext_irq          = ext_irq;
  assign src.protect_input_2  = protect_input_2;
  assign src.protect_input_3  = protect_input_3;

  assign wr_drive = reg_wr && (reg_addr == `HVDP_OFS_DRIVE);

  hvdp_trigger u_trig (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .src     (src),
    .en      (prot_r),
    .rise    (rise)
  );

  // the trip wins over a software write in the same cycle so a fault is
  // never masked; software sees cleared bits and decides what next
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_r <= `HVDP_DRIVE_RST;
    end else begin
      if (wr_drive) begin
        drive_r <= reg_wdata[`HVDP_CTRL_W-1:0];
      end
      if (drive_r.prot_en && rise) begin
        drive_r.level   <= 1'b0;
        drive_r.src_sel <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prot_r <= `HVDP_PROT_RST;
    end else if (reg_wr && (reg_addr == `HVDP_OFS_PROT)) begin
      prot_r <= reg_wdata[`HVDP_CTRL_W-1:0];
    end
  end

  // sticky-free one-cycle trip pulse, registered
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trip_r <= 1'b0;
    end else begin
      trip_r <= drive_r.prot_en && rise;
    end
  end

  // --------------------------------------------------------------------------
  // read port: data one cycle after the strobe, unmapped reads zero
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `HVDP_OFS_DRIVE: reg_rdata <= pad4(drive_r);
        `HVDP_OFS_PROT:  reg_rdata <= pad4(prot_r);
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // pin
  // --------------------------------------------------------------------------
  assign level_sel = drive_r.src_sel ? timer_drive_signal
                                     : drive_r.level;

  hvdp_pin u_pin (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .oe      (drive_r.oe),
    .level   (level_sel),
    .pin     (pin)
  );

  assign hv_pin_o     = pin.o;
  assign hv_pin_oe    = pin.oe;
  assign protect_trip = trip_r;

endmodule
`default_nettype wire

// ==== hvdp_top_assertions.sv ====
// port checker for the drive protect block
`timescale 1ns/1ps
`default_nettype none
`include "hvdp_cfg.svh"

module hvdp_top_assertions (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    arst_n,
  // register port
  input wire logic [`HVDP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  // sources
  input wire logic                    overcurrent_flag,
  input wire logic                    ext_irq,
  input wire logic                    protect_input_2,
  input wire logic                    protect_input_3,
  // pin and status
  input wire logic                    hv_pin_o,
  input wire logic                    hv_pin_oe,
  input wire logic                    protect_trip
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_drv_wr;
    reg_wr && reg_addr == 4'h0;
  endsequence

  a_oe_follow: assert property (s_drv_wr |->
    ##2 hv_pin_oe == $past(reg_wdata[2], 2)) else $error("enable lost");
  a_oe_cause: assert property ($changed(hv_pin_oe) |->
    $past(reg_wr && reg_addr == 4'h0, 2)) else $error("enable moved");
  a_data_lag: assert property (!hv_pin_oe ##1 !hv_pin_oe |-> !hv_pin_o)
    else $error("data ahead of enable");
  a_oe_apart: assert property ($changed(hv_pin_oe) |-> $stable(hv_pin_o))
    else $error("data moved with enable");
  a_trip_low: assert property (protect_trip |=> !hv_pin_o)
    else $error("pin high after trip");
  a_trip_cause: assert property (protect_trip |-> $past(|{protect_input_3,
    protect_input_2, ext_irq, overcurrent_flag}, 3)) else $error("no source");
  a_trip_pulse: assert property (protect_trip |=> !protect_trip)
    else $error("trip too long");
  a_rd_high: assert property (reg_rd |=> reg_rdata[7:4] == 4'h0)
    else $error("upper bits set");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
endmodule

bind hvdp_top hvdp_top_assertions chk_u (.*);
`default_nettype wire

// ==== hvdp_top_test.sv ====
// self-checking bench for the drive protect block
`timescale 1ns/1ps
`default_nettype none
`include "hvdp_cfg.svh"

module hvdp_top_test;
  logic ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, tmr = 0;
  logic [`HVDP_ADDR_W-1:0] reg_addr = '0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic [3:0]  src_v = 4'h0;
  logic        hv_pin_o, hv_pin_oe, protect_trip, gate, ocf;
  int          errors = 0, n_compared = 0, cyc = 0, n_trips = 0;
  // {control, timer, oe, o}
  logic [10:0] rows [8] = '{11'h022, 11'h02b, 11'h008, 11'h037,
                            11'h032, 11'h03a, 11'h7ab, 11'h01c};

  hvdp_top dut_u (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .overcurrent_flag(ocf), .ext_irq(src_v[1]),
    .protect_input_2(src_v[2]), .protect_input_3(src_v[3]),
    .timer_drive_signal(tmr), .hv_pin_o, .hv_pin_oe, .protect_trip);
  hvdp_mos mos_u (.ref_clk, .gate_o(hv_pin_o), .gate_oe(hv_pin_oe),
    .short_fault(src_v[0]), .gate(gate), .overcurrent_flag(ocf));

  always #5 ref_clk = ~ref_clk;

  task automatic summarize();
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (protect_trip === 1'b1) begin
      n_trips++;
    end
    if (cyc == 2000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask

  // source raised while the pin drives high, then released
  task automatic trip(input logic [7:0] pen, drv, e, input int i);
    wr(4'h1, pen);
    wr(4'h0, drv);
    tmr <= 1'b1;
    repeat (3) @(posedge ref_clk);
    src_v <= 4'h1 << i;
    repeat (8) @(posedge ref_clk);
    src_v <= 4'h0;
    repeat (6) @(posedge ref_clk);
    rd(4'h0, e);
  endtask

  // ---------------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1 chk("pin_rst", 8'h00, {6'h00, hv_pin_oe, hv_pin_o});
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      tmr <= rows[i][2];
      wr(4'h0, rows[i][10:3]);
      repeat (3) @(posedge ref_clk);
      #1 chk("pin", {5'h00, rows[i][1:0], rows[i][0]},
             {5'h00, hv_pin_oe, hv_pin_o, gate});
      rd(4'h0, rows[i][10:3] & 8'h0f);
    end
    for (int i = 0; i < 4; i++) begin
      trip(8'h01 << i, 8'h07, 8'h07, i);
      trip(8'h01 << ((i + 1) % 4), 8'h0f, 8'h0f, i);
      trip(8'h01 << i, 8'h0f, 8'h0c, i);
      chk("pin_trip", 8'h02, {6'h00, hv_pin_oe, hv_pin_o});
    end
    // trip clear lands on the same edge as a software write of 0x0f
    src_v <= 4'h8;
    @(posedge ref_clk);
    wr(4'h0, 8'h0f);
    src_v <= 4'h0;
    rd(4'h0, 8'h0c);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h00);
    rd(4'h0, 8'h0c);
    wr(4'h1, 8'hfa);
    rd(4'h1, 8'h0a);
    // reset in mid-run while the pin drives
    arst_n <= 1'b0;
    #1 chk("pin_mid_rst", 8'h00, {6'h00, hv_pin_oe, hv_pin_o});
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    chk("trips", 8'h05, n_trips[7:0]);
    summarize();
  end
endmodule
`default_nettype wire

// ==== hvdp_trigger.sv ====
// protection trigger: gated OR of sources, synchronised, rising edge
`timescale 1ns/1ps
`default_nettype none
`include "hvdp_cfg.svh"

module hvdp_trigger
  import hvdp_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // sources and enables
  input  wire hvdp_src_t  src,
  input  wire hvdp_prot_t en,
  // result
  output logic       rise
);

  logic any_src;
  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  assign any_src = (src.overcurrent_flag & en.oc_en)
                 | (src.ext_irq & en.irq_en)
                 | (src.protect_input_2 & en.src2_en)
                 | (src.protect_input_3 & en.src3_en);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= any_src;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;

endmodule
`default_nettype wire
